// >>> pkg/tmis_defs.svh
// Constants, letter codes and timing counts for the tuner mode indicator sequencer
`ifndef TMIS_DEFS_SVH
`define TMIS_DEFS_SVH

`define TMIS_CLK_HZ 10000000
`define TMIS_RELAY_W 15
`define TMIS_ADC_W 10
// Morse time unit
`define TMIS_UNIT_MS 60
`define TMIS_UNIT_CYC ((`TMIS_CLK_HZ / 1000) * `TMIS_UNIT_MS)
// Activity period before sleep
`define TMIS_ACTIVE_S 180
`define TMIS_ACTIVE_CYC (`TMIS_CLK_HZ * `TMIS_ACTIVE_S)
// Long press threshold, 1/3 s, rounded up
`define TMIS_LONG_NUM_S 1
`define TMIS_LONG_DEN 3
`define TMIS_LONG_CYC ((`TMIS_CLK_HZ * `TMIS_LONG_NUM_S + `TMIS_LONG_DEN - 1) / `TMIS_LONG_DEN)
// Search time limit
`define TMIS_SEARCH_S 15
`define TMIS_SEARCH_CYC (`TMIS_CLK_HZ * `TMIS_SEARCH_S)
// Fresh samples awaited after each relay step
`define TMIS_SETTLE_N 2
// Letters: length, then elements MSB first, 1 is a dash
`define TMIS_LTR_P 7'h46
`define TMIS_LTR_V 7'h41
`define TMIS_LTR_T 7'h18
`define TMIS_LTR_S 7'h30
`define TMIS_LTR_E 7'h10
`define TMIS_LTR_Y 7'h4B
`define TMIS_LTR_R 7'h34
`define TMIS_LTR_N 7'h28
`define TMIS_LTR_B 7'h48
`define TMIS_LTR_O 7'h3E
`define TMIS_FAIL_REPS 2'h3

`endif

// >>> pkg/tmis_pkg.sv
// Types for the tuner mode indicator sequencer
`include "tmis_defs.svh"
package tmis_pkg;

  typedef enum logic [2:0] {ST_OFF, ST_SHOW, ST_MORSE, ST_INIT, ST_SETTLE, ST_EVAL} tmis_state_t;

  typedef enum logic [2:0] {
    FORWARD_POWER_METER_MODE,
    MATCH_SEARCH_MODE,
    SUPPLY_VOLTAGE_METER_MODE,
    NETWORK_BYPASS_MODE,
    LIVE_VSWR_MODE
  } tmis_mode_t;

  typedef enum logic [1:0] {AFT_SHOW, AFT_TUNE, AFT_SLEEP} tmis_after_t;

  typedef struct packed {
    logic [2:0] len;
    logic [3:0] pat;
  } tmis_letter_t;

  typedef struct packed {
    logic [31:0] cnt;
    logic short_ev;
    logic long_ev;
  } tmis_btn_t;

  typedef logic [`TMIS_RELAY_W-1:0] tmis_relay_t;
  typedef logic [`TMIS_ADC_W-1:0] tmis_adc_t;

  typedef struct packed {
    tmis_state_t st;
    tmis_mode_t mode;
    tmis_after_t after;
    tmis_letter_t letter;
    logic [1:0] elem;
    logic lit;
    logic [1:0] reps;
    logic [31:0] unit_cnt;
    logic [31:0] act_cnt;
    logic [31:0] tmo_cnt;
    logic top_s1;
    logic top_s2;
    logic bot_s1;
    logic bot_s2;
    logic [31:0] top_cnt;
    logic [31:0] bot_cnt;
    tmis_adc_t fwd;
    tmis_adc_t refl;
    tmis_adc_t sup;
    tmis_adc_t best_fwd;
    tmis_adc_t best_ref;
    tmis_relay_t best_relay;
    tmis_relay_t prev_relay;
    tmis_relay_t relay;
    logic relay_pulse;
    logic nvm_wr;
    logic woke_pwr;
    logic byp_cnt;
    logic ovl;
    logic [14:0] lfsr;
    logic [1:0] settle;
    logic [2:0] led;
    logic hold;
  } tmis_regs_t;

endpackage

// >>> src/tmis_top.sv
// Mode indicator, match search and sleep sequencer of the antenna tuner
`timescale 1ns/1ns
`default_nettype none
`include "tmis_defs.svh"
module tmis_top #(
  parameter int UNIT_CYC = `TMIS_UNIT_CYC,
  parameter int ACTIVE_CYC = `TMIS_ACTIVE_CYC,
  parameter int LONG_CYC = `TMIS_LONG_CYC,
  parameter int SEARCH_CYC = `TMIS_SEARCH_CYC,
  // ADC codes of the power and supply thresholds
  parameter logic [9:0] P_MIN = 10'h020,
  parameter logic [9:0] P_2W = 10'h080,
  parameter logic [9:0] P_4W = 10'h100,
  parameter logic [9:0] P_TUNE_MAX = 10'h180,
  parameter logic [9:0] P_OVL = 10'h1E0,
  parameter logic [9:0] V_8P1 = 10'h200,
  parameter logic [9:0] V_8P7 = 10'h228,
  parameter logic [9:0] V_9P3 = 10'h250,
  parameter logic [9:0] V_9P9 = 10'h278,
  parameter logic [9:0] V_10P5 = 10'h2A0
) (
  // Clock and reset
  input wire logic I_CLK,
  input wire logic I_NRST,
  // Buttons, raw pins, high while pressed
  input wire logic I_BTN_TOP,
  input wire logic I_BTN_BOT,
  // Bridge and supply samples
  input wire logic I_ADC_VALID,
  input wire logic [9:0] I_FWD_ADC,
  input wire logic [9:0] I_REF_ADC,
  input wire logic [9:0] I_SUP_ADC,
  // Non-volatile match store
  input wire logic [14:0] I_NVM_RDATA,
  output logic O_NVM_WR,
  output logic [14:0] O_NVM_WDATA,
  // Relays, LEDs, power hold
  output logic [14:0] O_RELAY,
  output logic O_RELAY_PULSE,
  output logic [2:0] O_LED,
  output logic O_PWR_HOLD
);

  tmis_pkg::tmis_regs_t s_q;
  tmis_pkg::tmis_regs_t s_d;
  tmis_pkg::tmis_btn_t top_b;
  tmis_pkg::tmis_btn_t bot_b;
  logic better;
  logic last;
  logic [1:0] band;

  // Element length in cycles less one
  function automatic logic [31:0] elem_cyc(input tmis_pkg::tmis_letter_t l,
                                           input logic [1:0] idx);
    elem_cyc = l.pat[2'h3 - idx] ? 32'(3 * UNIT_CYC - 1) : 32'(UNIT_CYC - 1);
  endfunction

  // Start a letter on all three LEDs
  function automatic tmis_pkg::tmis_regs_t play(input tmis_pkg::tmis_regs_t s,
      input logic [6:0] code, input logic [1:0] reps, input tmis_pkg::tmis_after_t aft);
    play = s;
    play.st = tmis_pkg::ST_MORSE;
    play.letter = tmis_pkg::tmis_letter_t'(code);
    play.reps = reps;
    play.after = aft;
    play.elem = 2'h0;
    play.lit = 1'b1;
    play.unit_cnt = elem_cyc(tmis_pkg::tmis_letter_t'(code), 2'h0);
    play.led = 3'h7;
  endfunction

  // Press timing: long once at threshold, short on early release
  function automatic tmis_pkg::tmis_btn_t btn(input logic held, input logic [31:0] cnt);
    btn.cnt = cnt;
    btn.short_ev = 1'b0;
    btn.long_ev = 1'b0;
    if (held) begin
      if (cnt != 32'(LONG_CYC)) btn.cnt = cnt + 32'h1;
      btn.long_ev = (cnt == 32'(LONG_CYC - 1));
    end else begin
      btn.short_ev = (cnt != 32'h0) && (cnt < 32'(LONG_CYC - 1));
      btn.cnt = 32'h0;
    end
  endfunction

  // VSWR band from both powers: r^2 = refl/fwd against 1.5, 2.5, 3.5
  function automatic logic [1:0] vswr_band(input logic [9:0] f, input logic [9:0] r);
    logic [16:0] fw;
    logic [16:0] rw;
    fw = {7'h00, f};
    rw = {7'h00, r};
    if (rw * 17'h19 < fw) vswr_band = 2'h0;
    else if (rw * 17'h31 < fw * 17'h09) vswr_band = 2'h1;
    else if (rw * 17'h51 < fw * 17'h19) vswr_band = 2'h2;
    else vswr_band = 2'h3;
  endfunction

  // Measurement shown per mode
  function automatic logic [2:0] disp(input tmis_pkg::tmis_regs_t s);
    logic [2:0] vs;
    vs = 3'h7;
    unique case (vswr_band(s.fwd, s.refl))
      2'h0: vs = 3'h1;
      2'h1: vs = 3'h2;
      2'h2: vs = 3'h4;
      2'h3: vs = 3'h7;
    endcase
    unique case (s.mode)
      tmis_pkg::FORWARD_POWER_METER_MODE: begin
        if (s.fwd < P_MIN) disp = 3'h0;
        else if (s.fwd < P_2W) disp = 3'h1;
        else if (s.fwd < P_4W) disp = 3'h2;
        else if (s.fwd <= P_OVL) disp = 3'h4;
        else disp = 3'h7;
      end
      tmis_pkg::SUPPLY_VOLTAGE_METER_MODE: begin
        if (s.sup < V_8P1) disp = 3'h0;
        else if (s.sup < V_8P7) disp = 3'h1;
        else if (s.sup < V_9P3) disp = 3'h2;
        else if (s.sup < V_9P9) disp = 3'h4;
        else if (s.sup < V_10P5) disp = 3'h6;
        else disp = 3'h7;
      end
      // Bypass meters only with enough drive
      tmis_pkg::NETWORK_BYPASS_MODE: disp = (s.fwd < P_MIN) ? 3'h0 : vs;
      tmis_pkg::MATCH_SEARCH_MODE, tmis_pkg::LIVE_VSWR_MODE: disp = vs;
      default: disp = 3'h0;
    endcase
  endfunction

  assign top_b = btn(s_q.top_s2, s_q.top_cnt);
  assign bot_b = btn(s_q.bot_s2, s_q.bot_cnt);
  assign last = ({1'b0, s_q.elem} == s_q.letter.len - 3'h1);
  assign band = vswr_band(s_q.fwd, s_q.refl);
  // Lower reflected share than the best so far, cross-multiplied
  assign better = (s_q.best_fwd == 10'h000) ||
                  ({10'h000, s_q.refl} * {10'h000, s_q.best_fwd} <
                   {10'h000, s_q.best_ref} * {10'h000, s_q.fwd});

  // Next state of the whole sequencer
  always_comb begin
    s_d = s_q;
    s_d.relay_pulse = 1'b0;
    s_d.nvm_wr = 1'b0;
    // Pins pass two flops before any logic
    s_d.top_s1 = I_BTN_TOP;
    s_d.top_s2 = s_q.top_s1;
    s_d.bot_s1 = I_BTN_BOT;
    s_d.bot_s2 = s_q.bot_s1;
    s_d.top_cnt = top_b.cnt;
    s_d.bot_cnt = bot_b.cnt;
    // Free-running, so press timing seeds the search path
    s_d.lfsr = {s_q.lfsr[13:0], ~(s_q.lfsr[14] ^ s_q.lfsr[13])};
    if (I_ADC_VALID) begin
      s_d.fwd = I_FWD_ADC;
      s_d.refl = I_REF_ADC;
      s_d.sup = I_SUP_ADC;
    end
    if (s_q.act_cnt != 32'h0) s_d.act_cnt = s_q.act_cnt - 32'h1;
    if (s_q.tmo_cnt != 32'h0) s_d.tmo_cnt = s_q.tmo_cnt - 32'h1;
    if (s_q.fwd <= P_OVL) s_d.ovl = 1'b0;
    unique case (s_q.st)
      // Asleep: only the top button wakes
      tmis_pkg::ST_OFF: begin
        s_d.led = 3'h0;
        s_d.hold = 1'b0;
        s_d.byp_cnt = 1'b0;
        if (top_b.long_ev) begin
          s_d.hold = 1'b1;
          s_d.woke_pwr = 1'b0;
          s_d.mode = tmis_pkg::MATCH_SEARCH_MODE;
          s_d.act_cnt = 32'(ACTIVE_CYC - 1);
          s_d = play(s_d, `TMIS_LTR_T, 2'h0, tmis_pkg::AFT_TUNE);
        end else if (top_b.short_ev) begin
          s_d.hold = 1'b1;
          s_d.woke_pwr = 1'b1;
          s_d.mode = tmis_pkg::FORWARD_POWER_METER_MODE;
          s_d.act_cnt = 32'(ACTIVE_CYC - 1);
          s_d = play(s_d, `TMIS_LTR_P, 2'h0, tmis_pkg::AFT_SHOW);
        end
      end
      // Measurement display and button handling
      tmis_pkg::ST_SHOW: begin
        s_d.led = disp(s_q);
        if (s_q.act_cnt == 32'h0) begin
          s_d = play(s_d, `TMIS_LTR_O, 2'h0, tmis_pkg::AFT_SLEEP);
        end else if (top_b.long_ev) begin
          s_d.mode = tmis_pkg::MATCH_SEARCH_MODE;
          s_d.byp_cnt = 1'b0;
          s_d.act_cnt = 32'(ACTIVE_CYC - 1);
          s_d = play(s_d, `TMIS_LTR_T, 2'h0, tmis_pkg::AFT_TUNE);
        end else if (top_b.short_ev) begin
          s_d.mode = tmis_pkg::FORWARD_POWER_METER_MODE;
          s_d.act_cnt = 32'(ACTIVE_CYC - 1);
          s_d = play(s_d, `TMIS_LTR_P, 2'h0, tmis_pkg::AFT_SHOW);
        end else if (bot_b.long_ev && !s_q.byp_cnt) begin
          s_d.byp_cnt = 1'b1;
          s_d.prev_relay = s_q.relay;
          s_d.relay = '0;
          s_d.relay_pulse = 1'b1;
          s_d.mode = tmis_pkg::NETWORK_BYPASS_MODE;
          s_d.act_cnt = 32'(ACTIVE_CYC - 1);
          s_d = play(s_d, `TMIS_LTR_Y, 2'h0, tmis_pkg::AFT_SHOW);
        end else if (bot_b.long_ev) begin
          // Second bypass press: stored match after a power wake
          s_d.byp_cnt = 1'b0;
          s_d.relay = s_q.woke_pwr ? I_NVM_RDATA : s_q.prev_relay;
          s_d.relay_pulse = 1'b1;
          s_d.mode = tmis_pkg::LIVE_VSWR_MODE;
          s_d.act_cnt = 32'(ACTIVE_CYC - 1);
          s_d = play(s_d, `TMIS_LTR_R, 2'h0, tmis_pkg::AFT_SHOW);
        end else if (bot_b.short_ev &&
                     (s_q.mode == tmis_pkg::FORWARD_POWER_METER_MODE ||
                      s_q.mode == tmis_pkg::SUPPLY_VOLTAGE_METER_MODE)) begin
          s_d.mode = tmis_pkg::SUPPLY_VOLTAGE_METER_MODE;
          s_d.act_cnt = 32'(ACTIVE_CYC - 1);
          s_d = play(s_d, `TMIS_LTR_B, 2'h0, tmis_pkg::AFT_SHOW);
        end else if (s_q.mode == tmis_pkg::FORWARD_POWER_METER_MODE &&
                     s_q.fwd > P_OVL && !s_q.ovl) begin
          // Flag stops a repeat until power drops again
          s_d.ovl = 1'b1;
          s_d = play(s_d, `TMIS_LTR_V, 2'h0, tmis_pkg::AFT_SHOW);
        end
      end
      // Letter player; presses meanwhile are dropped
      tmis_pkg::ST_MORSE: begin
        if (s_q.unit_cnt != 32'h0) begin
          s_d.unit_cnt = s_q.unit_cnt - 32'h1;
        end else if (s_q.lit) begin
          s_d.lit = 1'b0;
          s_d.unit_cnt = last ? 32'(3 * UNIT_CYC - 1) : 32'(UNIT_CYC - 1);
        end else if (!last) begin
          s_d.elem = s_q.elem + 2'h1;
          s_d.lit = 1'b1;
          s_d.unit_cnt = elem_cyc(s_q.letter, s_q.elem + 2'h1);
        end else if (s_q.reps != 2'h0) begin
          s_d.reps = s_q.reps - 2'h1;
          s_d.elem = 2'h0;
          s_d.lit = 1'b1;
          s_d.unit_cnt = elem_cyc(s_q.letter, 2'h0);
        end else begin
          unique case (s_q.after)
            tmis_pkg::AFT_SHOW: s_d.st = tmis_pkg::ST_SHOW;
            tmis_pkg::AFT_SLEEP: begin
              s_d.st = tmis_pkg::ST_OFF;
              s_d.hold = 1'b0;
            end
            tmis_pkg::AFT_TUNE: begin
              if (s_q.fwd > P_TUNE_MAX)
                s_d = play(s_d, `TMIS_LTR_V, 2'h0, tmis_pkg::AFT_SHOW);
              else if (s_q.fwd < P_MIN)
                s_d = play(s_d, `TMIS_LTR_N, 2'h0, tmis_pkg::AFT_SHOW);
              else if (band == 2'h0)
                s_d = play(s_d, `TMIS_LTR_S, 2'h0, tmis_pkg::AFT_SHOW);
              else
                s_d.st = tmis_pkg::ST_INIT;
            end
            default: s_d.st = tmis_pkg::ST_SHOW;
          endcase
        end
        s_d.led = {3{s_d.lit}};
      end
      // Known relay state before searching
      tmis_pkg::ST_INIT: begin
        s_d.relay = '0;
        s_d.relay_pulse = 1'b1;
        s_d.best_relay = '0;
        s_d.best_fwd = 10'h000;
        s_d.best_ref = 10'h000;
        s_d.tmo_cnt = 32'(SEARCH_CYC - 1);
        s_d.settle = 2'(`TMIS_SETTLE_N);
        s_d.st = tmis_pkg::ST_SETTLE;
      end
      // Wait for fresh samples with RF on the new relays
      tmis_pkg::ST_SETTLE: begin
        s_d.led = 3'h0;
        if (I_ADC_VALID) begin
          if (s_q.settle == 2'h1) s_d.st = tmis_pkg::ST_EVAL;
          else s_d.settle = s_q.settle - 2'h1;
        end
      end
      // Greedy step: keep improvements, try one random relay flip
      tmis_pkg::ST_EVAL: begin
        if (better) begin
          s_d.best_relay = s_q.relay;
          s_d.best_fwd = s_q.fwd;
          s_d.best_ref = s_q.refl;
        end
        if (s_q.fwd < P_MIN) begin
          s_d.relay = better ? s_q.relay : s_q.best_relay;
          s_d.relay_pulse = 1'b1;
          s_d = play(s_d, `TMIS_LTR_N, 2'h0, tmis_pkg::AFT_SHOW);
        end else if (band == 2'h0) begin
          s_d.best_relay = s_q.relay;
          s_d.nvm_wr = 1'b1;
          s_d = play(s_d, `TMIS_LTR_S, 2'h0, tmis_pkg::AFT_SHOW);
        end else if (s_q.tmo_cnt == 32'h0) begin
          s_d.relay = better ? s_q.relay : s_q.best_relay;
          s_d.relay_pulse = 1'b1;
          s_d = play(s_d, `TMIS_LTR_E, `TMIS_FAIL_REPS, tmis_pkg::AFT_SHOW);
        end else begin
          s_d.relay = (better ? s_q.relay : s_q.best_relay) ^
                      (15'h0001 << ((s_q.lfsr[3:0] == 4'hF) ? 4'h0 : s_q.lfsr[3:0]));
          s_d.relay_pulse = 1'b1;
          s_d.settle = 2'(`TMIS_SETTLE_N);
          s_d.st = tmis_pkg::ST_SETTLE;
        end
      end
      default: s_d.st = tmis_pkg::ST_OFF;
    endcase
  end

  // State register; relays stay latched through sleep
  always_ff @(posedge I_CLK) begin
    if (!I_NRST) s_q <= '0;
    else s_q <= s_d;
  end

  // Outputs straight from flops
  assign O_LED = s_q.led;
  assign O_RELAY = s_q.relay;
  assign O_RELAY_PULSE = s_q.relay_pulse;
  assign O_NVM_WR = s_q.nvm_wr;
  assign O_NVM_WDATA = s_q.best_relay;
  assign O_PWR_HOLD = s_q.hold;

endmodule
`default_nettype wire

// >>> test/tmis_bridge_model.sv
// Behavioural bridge detector, supply sense and match store beside the sequencer
`timescale 1ns/1ns
`default_nettype none
module tmis_bridge_model (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // Bench controls
  input wire logic [9:0] i_fwd,
  input wire logic i_fail,
  // Sequencer side
  input wire logic [14:0] i_relay,
  input wire logic i_nvm_wr,
  input wire logic [14:0] i_nvm_wdata,
  output logic o_valid,
  output logic [9:0] o_fwd,
  output logic [9:0] o_ref,
  output logic [9:0] o_sup,
  output logic [14:0] o_nvm_rdata
);
  logic [1:0] div_q;
  logic [9:0] ref_v;
  // Match only with relay 3 closed; else a quarter comes back, never the worst band
  assign ref_v = (i_relay[3] && !i_fail) ? 10'h000 : {2'h0, i_fwd[9:2]};
  // Strobe every fourth cycle; the store keeps the last good word
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      div_q <= 2'h0;
      o_valid <= 1'b0;
      o_nvm_rdata <= 15'h0000;
    end else begin
      div_q <= div_q + 2'h1;
      o_valid <= div_q == 2'h3;
      if (i_nvm_wr) begin
        o_nvm_rdata <= i_nvm_wdata;
      end
    end
  end
  // Codes invert between strobes, so an off-strobe read shows up; supply fixed mid band
  assign o_fwd = o_valid ? i_fwd : ~i_fwd;
  assign o_ref = o_valid ? ref_v : ~ref_v;
  assign o_sup = o_valid ? 10'h240 : 10'h1BF;
endmodule
`default_nettype wire

// >>> test/tmis_props.sv
// Port-level assertions of the tuner mode indicator sequencer
`timescale 1ns/1ns
`default_nettype none
module tmis_props (
  // Clock, reset and inputs
  input wire logic I_CLK,
  input wire logic I_NRST,
  input wire logic I_BTN_TOP,
  input wire logic I_BTN_BOT,
  input wire logic I_ADC_VALID,
  input wire logic [9:0] I_FWD_ADC,
  input wire logic [9:0] I_REF_ADC,
  input wire logic [9:0] I_SUP_ADC,
  input wire logic [14:0] I_NVM_RDATA,
  // Outputs under watch
  input wire logic O_NVM_WR,
  input wire logic [14:0] O_NVM_WDATA,
  input wire logic [14:0] O_RELAY,
  input wire logic O_RELAY_PULSE,
  input wire logic [2:0] O_LED,
  input wire logic O_PWR_HOLD
);
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (!I_NRST);
  // All three lamps lit, and the wake edge
  sequence s_lit;
    O_LED == 3'h7;
  endsequence
  sequence s_wake;
    $rose(O_PWR_HOLD);
  endsequence
  chk_wake_ack: assert property (s_wake |-> s_lit)
    else $error("wake without letter");
  chk_first_element: assert property (s_wake |-> (!O_RELAY_PULSE) throughout (s_lit [*2]))
    else $error("first element too short");
  chk_store_pulse: assert property (O_NVM_WR |=> !O_NVM_WR)
    else $error("store write longer than a cycle");
  chk_store_word: assert property (O_NVM_WR |-> O_NVM_WDATA == O_RELAY && O_PWR_HOLD)
    else $error("stored word differs from relays");
  chk_store_then_s: assert property (O_NVM_WR |-> ##[0:4] s_lit)
    else $error("no success letter after store");
  chk_relay_strobe: assert property ($changed(O_RELAY) |-> O_RELAY_PULSE)
    else $error("relays moved without strobe");
  chk_strobe_single: assert property (O_RELAY_PULSE |=> !O_RELAY_PULSE)
    else $error("relay strobe longer than a cycle");
  chk_sleep_dark: assert property (!O_PWR_HOLD && !$past(O_PWR_HOLD) |-> O_LED == 3'h0)
    else $error("lamps lit while asleep");
  chk_sleep_latch: assert property (!O_PWR_HOLD |=> $stable(O_RELAY))
    else $error("relays moved while asleep");
endmodule
bind tmis_top tmis_props props_u (
  .I_CLK(I_CLK), .I_NRST(I_NRST), .I_BTN_TOP(I_BTN_TOP), .I_BTN_BOT(I_BTN_BOT),
  .I_ADC_VALID(I_ADC_VALID), .I_FWD_ADC(I_FWD_ADC), .I_REF_ADC(I_REF_ADC),
  .I_SUP_ADC(I_SUP_ADC), .I_NVM_RDATA(I_NVM_RDATA), .O_NVM_WR(O_NVM_WR),
  .O_NVM_WDATA(O_NVM_WDATA), .O_RELAY(O_RELAY), .O_RELAY_PULSE(O_RELAY_PULSE),
  .O_LED(O_LED), .O_PWR_HOLD(O_PWR_HOLD));
`default_nettype wire

// >>> test/tuner_mode_indicator_sequencer_tb_top.sv
// Self-checking bench of the tuner mode indicator sequencer
`timescale 1ns/1ns
`default_nettype none
module tuner_mode_indicator_sequencer_tb_top;
  localparam int UNIT = 2;
  localparam int LONG = 20;
  localparam int ACT = 2000;
  localparam int SRCH = 1500;
  localparam int LIMIT = 20000;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic btn_top = 1'b0;
  logic btn_bot = 1'b0;
  logic fail = 1'b0;
  logic [9:0] fwd = 10'h0A0;
  logic valid;
  logic [9:0] fwd_adc;
  logic [9:0] ref_adc;
  logic [9:0] sup_adc;
  logic [14:0] rdata;
  logic nvm_wr;
  logic [14:0] wdata;
  logic [14:0] relay;
  logic pulse;
  logic [2:0] led;
  logic hold;
  int n_fail = 0;
  int cmp_count = 0;
  int cyc = 0;
  tmis_top #(.UNIT_CYC(UNIT), .ACTIVE_CYC(ACT), .LONG_CYC(LONG), .SEARCH_CYC(SRCH)) dut_u (
    .I_CLK(clk), .I_NRST(nrst), .I_BTN_TOP(btn_top), .I_BTN_BOT(btn_bot),
    .I_ADC_VALID(valid), .I_FWD_ADC(fwd_adc), .I_REF_ADC(ref_adc), .I_SUP_ADC(sup_adc),
    .I_NVM_RDATA(rdata), .O_NVM_WR(nvm_wr), .O_NVM_WDATA(wdata), .O_RELAY(relay),
    .O_RELAY_PULSE(pulse), .O_LED(led), .O_PWR_HOLD(hold));
  tmis_bridge_model bridge_u (
    .i_clk(clk), .i_nrst(nrst), .i_fwd(fwd), .i_fail(fail), .i_relay(relay),
    .i_nvm_wr(nvm_wr), .i_nvm_wdata(wdata), .o_valid(valid), .o_fwd(fwd_adc),
    .o_ref(ref_adc), .o_sup(sup_adc), .o_nvm_rdata(rdata));
  // 10 MHz clock
  always #50 clk = ~clk;
  // Cycle ceiling cuts a hang short
  always @(posedge clk) begin
    cyc++;
    if (cyc == LIMIT) begin
      n_fail++;
      $display("MISMATCH cycle limit expected below %0d seen %0d", LIMIT, cyc);
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("SUMMARY compared %0d mismatched %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic cmp_led(input string what, input logic [2:0] exp);
    cmp_count++;
    if (led !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, led);
    end
  endtask
  task automatic cmp_word(input string what, input logic [14:0] exp, input logic [14:0] seen);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Far-side levels change at the rising edge, then sampling resumes at falling edges
  task automatic set_far(input logic [9:0] f, input logic fl);
    @(posedge clk);
    fwd <= f;
    fail <= fl;
    @(negedge clk);
  endtask
  task automatic press(input logic top, input int n);
    @(posedge clk);
    btn_top <= top;
    btn_bot <= !top;
    repeat (n) @(posedge clk);
    btn_top <= 1'b0;
    btn_bot <= 1'b0;
    @(negedge clk);
  endtask
  // Waits for a letter, then walks every element and gap cycle by cycle
  task automatic check_letter(input string m, input int wait_max);
    int k = 0;
    int d;
    while (led !== 3'h7 && k < wait_max) begin
      @(negedge clk);
      k++;
    end
    for (int i = 0; i < m.len(); i++) begin
      d = (m[i] == "-") ? 3 * UNIT : UNIT;
      repeat (d) begin
        cmp_led("letter lit", 3'h7);
        @(negedge clk);
      end
      d = (i == m.len() - 1) ? 3 * UNIT : UNIT;
      repeat (d) begin
        cmp_led("letter dark", 3'h0);
        @(negedge clk);
      end
    end
  endtask
  task automatic act(input logic top, input int n, input string m);
    fork
      press(top, n);
      check_letter(m, 300);
    join
  endtask
  task automatic t_wake_power();
    act(1'b1, 5, ".--.");
    repeat (3) @(negedge clk);
    cmp_led("power band", 3'h2);
    cmp_word("hold", 15'h0001, {14'h0, hold});
    $display("TEST wake_power done");
  endtask
  task automatic t_overload();
    set_far(10'h200, 1'b0);
    check_letter("...-", 300);
    repeat (3) @(negedge clk);
    cmp_led("overload band", 3'h7);
    set_far(10'h0A0, 1'b0);
    repeat (12) @(negedge clk);
    cmp_led("power band back", 3'h2);
    $display("TEST overload done");
  endtask
  task automatic t_supply();
    act(1'b0, 5, "-...");
    repeat (3) @(negedge clk);
    cmp_led("supply band", 3'h2);
    $display("TEST supply done");
  endtask
  task automatic t_tune_ok();
    int k = 0;
    act(1'b1, LONG + 10, "-");
    while (nvm_wr !== 1'b1 && k < 2 * SRCH) begin
      @(negedge clk);
      k++;
    end
    cmp_word("store strobe", 15'h0001, {14'h0, nvm_wr});
    check_letter("...", 300);
    cmp_word("matched relay", 15'h0001, {14'h0, relay[3]});
    cmp_word("stored relay", 15'h0001, {14'h0, rdata[3]});
    repeat (3) @(negedge clk);
    cmp_led("vswr band", 3'h1);
    // Already matched: success letter follows the T at once, no search
    act(1'b1, LONG + 10, "-");
    check_letter("...", 2);
    cmp_word("matched kept", rdata, relay);
    $display("TEST tune_ok done");
  endtask
  task automatic t_bypass();
    act(1'b0, LONG + 10, "-.--");
    cmp_word("bypass relays", 15'h0000, relay);
    // Open network reflects a quarter of the drive
    repeat (3) @(negedge clk);
    cmp_led("bypass vswr", 3'h4);
    act(1'b0, LONG + 10, ".-.");
    repeat (3) @(negedge clk);
    cmp_word("restored relays", rdata, relay);
    cmp_led("live vswr", 3'h1);
    $display("TEST bypass done");
  endtask
  task automatic t_sleep();
    check_letter("---", ACT + 500);
    repeat (3) @(negedge clk);
    cmp_word("hold off", 15'h0000, {14'h0, hold});
    cmp_led("asleep", 3'h0);
    cmp_word("latched relays", rdata, relay);
    $display("TEST sleep done");
  endtask
  task automatic t_tune_fail();
    int k = 0;
    int n = 0;
    logic [14:0] seen = 15'h0000;
    logic [14:0] first = 15'h7FFF;
    set_far(10'h0A0, 1'b1);
    act(1'b1, LONG + 10, "-");
    // Gather every relay word strobed while the search runs
    while (led !== 3'h7 && k < 2 * SRCH) begin
      if (pulse === 1'b1) begin
        if (n == 0) first = relay;
        seen = seen | relay;
        n++;
      end
      @(negedge clk);
      k++;
    end
    cmp_word("initial relays", 15'h0000, first);
    cmp_word("varied flips", 15'h0001, {14'h0, ($countones(seen) > 1)});
    repeat (4) check_letter(".", 2 * SRCH);
    cmp_word("kept best", 15'h0000, relay);
    repeat (3) @(negedge clk);
    cmp_led("poor vswr", 3'h4);
    // Woken by a tune: restore goes to the pre-bypass relays, not the store
    act(1'b0, LONG + 10, "-.--");
    act(1'b0, LONG + 10, ".-.");
    cmp_word("pre-bypass relays", 15'h0000, relay);
    $display("TEST tune_fail done");
  endtask
  task automatic t_tune_refuse();
    set_far(10'h1A0, 1'b0);
    act(1'b1, LONG + 10, "-");
    check_letter("...-", 300);
    set_far(10'h010, 1'b0);
    act(1'b1, LONG + 10, "-");
    check_letter("-.", 300);
    $display("TEST tune_refuse done");
  endtask
  // Reset for ten cycles, then the scenarios in order
  initial begin
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    @(negedge clk);
    cmp_led("reset dark", 3'h0);
    t_wake_power();
    t_overload();
    t_supply();
    t_tune_ok();
    t_bypass();
    t_sleep();
    t_tune_fail();
    t_tune_refuse();
    give_verdict();
  end
endmodule
`default_nettype wire
